// ==== rtl/pmc_power_mode_ctrl.sv ====
`timescale 1ns/1ns
module pmd_power_mode_ctrl
    import pmd_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Configuration
    input wire pmd_runreq_e runReq,
    input wire logic deepSleepSel,
    // Core sleep handshake
    input wire logic waitForIntInstr,
    input wire logic waitForEventInstr,
    // Wake sources
    input wire logic nestedIntWake,
    input wire logic asyncWakeEvent,
    // Memory access requests
    input wire logic eepromWrReq,
    input wire logic flashCmdReq,
    // Status and control
    output pmd_mode_e mode,
    output pmd_ctrl_s ctrl,
    output logic eepromWrGrant,
    output logic flashCmdGrant,
    output logic accessRejected
);
    typedef struct packed {
        pmd_mode_e mode;
        pmd_mode_e savedRun;
        logic restarting;
        logic [PMD_CNT_W-1:0] cnt;
        pmd_ctrl_s ctrl;
        logic eepromGrant;
        logic flashGrant;
        logic rejected;
    } pmd_state_s;

    pmd_state_s state_ff;
    pmd_state_s nxt_state;
    pmd_ctrl_s nxtCtrl;
    pmd_mode_e runTarget;
    logic sleepReq;

    pmd_mode_decode u_decode (
        .mode(nxt_state.mode),
        .restarting(nxt_state.restarting),
        .ctrl(nxtCtrl)
    );

    always_comb begin
        case (runReq)
            PMD_REQ_HS_RUN: runTarget = PMD_HS_RUN;
            PMD_REQ_LP_RUN: runTarget = PMD_LP_RUN;
            default: runTarget = PMD_RUN;
        endcase
    end

    always_comb begin
        sleepReq = waitForIntInstr || waitForEventInstr;
        nxt_state = state_ff;
        case (state_ff.mode)
            PMD_RUN, PMD_HS_RUN, PMD_LP_RUN: begin
                if (sleepReq) begin
                    // Remember where to come back to
                    nxt_state.savedRun = state_ff.mode;
                    if (deepSleepSel) begin
                        nxt_state.mode = (state_ff.mode == PMD_LP_RUN)
                            ? PMD_LP_STOP : PMD_STOP;
                    end else begin
                        nxt_state.mode = (state_ff.mode == PMD_LP_RUN)
                            ? PMD_LP_WAIT : PMD_WAIT;
                    end
                end else if (runTarget != state_ff.mode) begin
                    // Speed changes only via normal run
                    nxt_state.mode = (state_ff.mode == PMD_RUN)
                        ? runTarget : PMD_RUN;
                end
            end
            PMD_WAIT, PMD_LP_WAIT: begin
                if (nestedIntWake) begin
                    nxt_state.mode = state_ff.savedRun;
                end
            end
            PMD_STOP, PMD_LP_STOP: begin
                if (state_ff.restarting) begin
                    // Interrupt controller cannot act until clocks are back
                    if (state_ff.cnt == PMD_CNT_W'(PMD_CLK_RESTART_CYC - 1))
                    begin
                        nxt_state.restarting = 1'b0;
                        nxt_state.cnt = '0;
                        nxt_state.mode = state_ff.savedRun;
                    end else begin
                        nxt_state.cnt = state_ff.cnt + PMD_CNT_W'(1);
                    end
                end else if (asyncWakeEvent) begin
                    nxt_state.restarting = 1'b1;
                    nxt_state.cnt = '0;
                end
            end
            default: nxt_state.mode = PMD_RUN;
        endcase
        nxt_state.ctrl = nxtCtrl;
        // Gate on current mode so a request never slips through a change
        nxt_state.eepromGrant = eepromWrReq
            && state_ff.ctrl.eepromWrAllow;
        nxt_state.flashGrant = flashCmdReq
            && state_ff.ctrl.flashCmdAllow;
        nxt_state.rejected = (eepromWrReq && !state_ff.ctrl.eepromWrAllow)
            || (flashCmdReq && !state_ff.ctrl.flashCmdAllow);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= '{mode: PMD_RUN, savedRun: PMD_RUN,
                restarting: 1'b0, cnt: '0, ctrl: PMD_CTRL_RST,
                eepromGrant: 1'b0, flashGrant: 1'b0, rejected: 1'b0};
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign mode = state_ff.mode;
    assign ctrl = state_ff.ctrl;
    assign eepromWrGrant = state_ff.eepromGrant;
    assign flashCmdGrant = state_ff.flashGrant;
    assign accessRejected = state_ff.rejected;

    property p_sleepEntry;
        @(posedge clk) disable iff (!rst_n)
        (sleepReq && (mode == PMD_RUN) && !deepSleepSel)
            |=> (mode == PMD_WAIT);
    endproperty
    a_sleepEntry: assert property (p_sleepEntry)
        else $error("sleep did not enter wait");

    property p_deepEntry;
        @(posedge clk) disable iff (!rst_n)
        (sleepReq && (mode == PMD_LP_RUN) && deepSleepSel)
            |=> (mode == PMD_LP_STOP);
    endproperty
    a_deepEntry: assert property (p_deepEntry)
        else $error("deep sleep from slow run did not enter slow stop");

    property p_runCore;
        @(posedge clk) disable iff (!rst_n)
        ((mode == PMD_RUN) || (mode == PMD_HS_RUN))
            |-> (ctrl.coreClkEn && ctrl.periphClkEn);
    endproperty
    a_runCore: assert property (p_runCore)
        else $error("core or peripherals off in run");

    property p_waitCore;
        @(posedge clk) disable iff (!rst_n)
        ((mode == PMD_WAIT) || (mode == PMD_LP_WAIT))
            |-> (!ctrl.coreClkEn && ctrl.periphClkEn);
    endproperty
    a_waitCore: assert property (p_waitCore)
        else $error("wait mode core or peripheral state wrong");

    property p_stopState;
        @(posedge clk) disable iff (!rst_n)
        ((mode == PMD_STOP) || (mode == PMD_LP_STOP))
            |-> (!ctrl.coreClkEn && !ctrl.periphClkEn
                && !ctrl.nestedIntEn && ctrl.asyncWakeEn
                && ctrl.sramRetain);
    endproperty
    a_stopState: assert property (p_stopState)
        else $error("stop mode enables wrong");

    property p_waitWake;
        @(posedge clk) disable iff (!rst_n)
        ((mode == PMD_WAIT) && nestedIntWake)
            |=> (mode == $past(state_ff.savedRun));
    endproperty
    a_waitWake: assert property (p_waitWake)
        else $error("wait did not wake to saved run mode");

    property p_stopWake;
        @(posedge clk) disable iff (!rst_n)
        (((mode == PMD_STOP) || (mode == PMD_LP_STOP)) && asyncWakeEvent
            && !state_ff.restarting)
            |=> ctrl.clkRestartReq ##10 (mode == PMD_RUN
                || mode == PMD_HS_RUN || mode == PMD_LP_RUN);
    endproperty
    a_stopWake: assert property (p_stopWake)
        else $error("stop wake did not restart clocks and resume");

    property p_vlpDet;
        @(posedge clk) disable iff (!rst_n)
        ((mode == PMD_LP_RUN) || (mode == PMD_LP_WAIT)
            || (mode == PMD_LP_STOP))
            |-> (!ctrl.lowVoltDetEn && ctrl.lowSpeedEn);
    endproperty
    a_vlpDet: assert property (p_vlpDet)
        else $error("vlp detector or speed wrong");

    property p_stopLvd;
        @(posedge clk) disable iff (!rst_n)
        (mode == PMD_STOP) |-> (ctrl.lowVoltDetEn && ctrl.regRetain
            && ctrl.analogEn);
    endproperty
    a_stopLvd: assert property (p_stopLvd)
        else $error("stop retention or detector wrong");

    property p_flashBlock;
        @(posedge clk) disable iff (!rst_n)
        (flashCmdReq && ((mode == PMD_HS_RUN) || (mode == PMD_LP_RUN)))
            |=> (!flashCmdGrant && accessRejected);
    endproperty
    a_flashBlock: assert property (p_flashBlock)
        else $error("flash command granted in restricted mode");

    c_wait: cover property (@(posedge clk) disable iff (!rst_n)
        mode == PMD_WAIT ##1 mode == PMD_RUN);
    c_stop: cover property (@(posedge clk) disable iff (!rst_n)
        mode == PMD_STOP ##1 ctrl.clkRestartReq);
    c_slowStop: cover property (@(posedge clk) disable iff (!rst_n)
        mode == PMD_LP_STOP ##1 mode == PMD_LP_RUN);
    c_fastRun: cover property (@(posedge clk) disable iff (!rst_n)
        mode == PMD_HS_RUN);
endmodule

// ==== rtl/pmc_pkg.sv ====
package pmd_pkg;

    typedef enum logic [2:0] {
        PMD_RUN,
        PMD_HS_RUN,
        PMD_LP_RUN,
        PMD_WAIT,
        PMD_LP_WAIT,
        PMD_STOP,
        PMD_LP_STOP
    } pmd_mode_e;

    // Requested run configuration from software-side control
    typedef enum logic [1:0] {
        PMD_REQ_RUN,
        PMD_REQ_HS_RUN,
        PMD_REQ_LP_RUN
    } pmd_runreq_e;

    // Per-mode enables driven to the rest of the chip
    typedef struct packed {
        logic coreClkEn;
        logic periphClkEn;
        logic lowSpeedEn;
        logic lowVoltDetEn;
        logic nestedIntEn;
        logic asyncWakeEn;
        logic analogEn;
        logic serialDmaEn;
        logic sramRetain;
        logic regRetain;
        logic flashCmdAllow;
        logic eepromWrAllow;
        logic clkRestartReq;
    } pmd_ctrl_s;

    localparam pmd_ctrl_s PMD_CTRL_RST = '{
        coreClkEn: 1'b1, periphClkEn: 1'b1, lowSpeedEn: 1'b0,
        lowVoltDetEn: 1'b1, nestedIntEn: 1'b1, asyncWakeEn: 1'b0,
        analogEn: 1'b1, serialDmaEn: 1'b1, sramRetain: 1'b1,
        regRetain: 1'b1, flashCmdAllow: 1'b1, eepromWrAllow: 1'b1,
        clkRestartReq: 1'b0
    };

    // Cycles the clock restart request is held before clocks are deemed running
    localparam int PMD_CLK_RESTART_NS = 40;
    localparam int PMD_CLK_PERIOD_NS = 4;
    localparam int PMD_CLK_RESTART_CYC =
        (PMD_CLK_RESTART_NS + PMD_CLK_PERIOD_NS - 1) / PMD_CLK_PERIOD_NS;
    localparam int PMD_CNT_W = 4;

endpackage

// ==== rtl/pmc_mode_decode.sv ====
`timescale 1ns/1ns
module pmd_mode_decode
    import pmd_pkg::*;
(
    // Mode in
    input wire pmd_mode_e mode,
    input wire logic restarting,
    // Enables out
    output pmd_ctrl_s ctrl
);
    logic isVlp;
    logic isStop;

    always_comb begin
        isVlp = (mode == PMD_LP_RUN) || (mode == PMD_LP_WAIT)
            || (mode == PMD_LP_STOP);
        isStop = (mode == PMD_STOP) || (mode == PMD_LP_STOP);
        ctrl = PMD_CTRL_RST;
        // Core runs only in the three run configurations
        ctrl.coreClkEn = (mode == PMD_RUN) || (mode == PMD_HS_RUN)
            || (mode == PMD_LP_RUN);
        ctrl.periphClkEn = !isStop;
        ctrl.lowSpeedEn = isVlp;
        ctrl.lowVoltDetEn = !isVlp;
        ctrl.nestedIntEn = !isStop;
        ctrl.asyncWakeEn = isStop;
        ctrl.analogEn = 1'b1;
        ctrl.serialDmaEn = (mode != PMD_STOP);
        ctrl.sramRetain = 1'b1;
        ctrl.regRetain = (mode != PMD_LP_STOP);
        ctrl.flashCmdAllow = !isVlp && (mode != PMD_HS_RUN);
        ctrl.eepromWrAllow = !isVlp && (mode != PMD_HS_RUN);
        ctrl.clkRestartReq = restarting;
    end
endmodule

// ==== testbench/pmc_core_model.sv ====
`timescale 1ns/1ns
module pmd_core_model (
    // Clock and commands from the bench
    input wire logic clk,
    input wire logic [1:0] sleepCmd,
    input wire logic [1:0] wakeCmd,
    // Core and wake pins
    output logic waitForIntInstr,
    output logic waitForEventInstr,
    output logic nestedIntWake,
    output logic asyncWakeEvent
);
    // One process owns the pins; pulses leave on the falling edge
    initial begin
        waitForIntInstr = 1'b0;
        waitForEventInstr = 1'b0;
        nestedIntWake = 1'b0;
        asyncWakeEvent = 1'b0;
        forever begin
            @(negedge clk);
            waitForIntInstr <= (sleepCmd == 2'h1);
            waitForEventInstr <= (sleepCmd == 2'h2);
            nestedIntWake <= (wakeCmd == 2'h1);
            asyncWakeEvent <= (wakeCmd == 2'h2);
        end
    end
endmodule

// ==== testbench/tb_pmc_power_mode_ctrl.sv ====
`timescale 1ns/1ns
module tb_pmd_power_mode_ctrl;
    import pmd_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, deepSleepSel = 1'b0;
    logic eepromWrReq = 1'b0, flashCmdReq = 1'b0;
    logic [1:0] sleepCmd = 2'h0, wakeCmd = 2'h0;
    pmd_runreq_e runReq = PMD_REQ_RUN;
    logic sleepIntr, sleepEvt, nestWake, asyncWake;
    logic eepromWrGrant, flashCmdGrant, accessRejected;
    pmd_mode_e mode;
    pmd_ctrl_s ctrl;
    int n_fail = 0, checks = 0;
    pmd_core_model core (.clk(clk), .sleepCmd(sleepCmd), .wakeCmd(wakeCmd),
        .waitForIntInstr(sleepIntr), .waitForEventInstr(sleepEvt),
        .nestedIntWake(nestWake), .asyncWakeEvent(asyncWake));
    pmd_power_mode_ctrl DUT (.clk(clk), .rst_n(rst_n), .runReq(runReq),
        .deepSleepSel(deepSleepSel), .waitForIntInstr(sleepIntr),
        .waitForEventInstr(sleepEvt), .nestedIntWake(nestWake),
        .asyncWakeEvent(asyncWake), .eepromWrReq(eepromWrReq),
        .flashCmdReq(flashCmdReq), .mode(mode), .ctrl(ctrl),
        .eepromWrGrant(eepromWrGrant), .flashCmdGrant(flashCmdGrant),
        .accessRejected(accessRejected));
    initial begin
        forever #2 clk = ~clk;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic chk(input logic ok, input string what);
        checks++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    function automatic pmd_mode_e runMode(input pmd_runreq_e r);
        return r == PMD_REQ_LP_RUN ? PMD_LP_RUN :
            (r == PMD_REQ_HS_RUN ? PMD_HS_RUN : PMD_RUN);
    endfunction
    task automatic pulse(input logic sl, input logic [1:0] k);
        if (sl) begin
            sleepCmd <= k;
        end else begin
            wakeCmd <= k;
        end
        tick(1);
        sleepCmd <= 2'h0;
        wakeCmd <= 2'h0;
        tick(1);
    endtask
    task automatic access(input logic ok, input string what);
        eepromWrReq <= 1'b1;
        flashCmdReq <= 1'b1;
        tick(1);
        eepromWrReq <= 1'b0;
        flashCmdReq <= 1'b0;
        chk(eepromWrGrant === ok && flashCmdGrant === ok &&
            accessRejected === ~ok, what);
        tick(1);
    endtask
    task automatic run_cfg(input pmd_runreq_e r);
        // Up to two steps when walking across normal run
        runReq <= r;
        tick(4);
        chk(mode === runMode(r), "run mode");
        chk(ctrl.coreClkEn === 1'b1 && ctrl.periphClkEn === 1'b1,
            "run en");
        chk(ctrl.lowVoltDetEn === (r != PMD_REQ_LP_RUN),
            "run detector");
        chk(ctrl.lowSpeedEn === (r == PMD_REQ_LP_RUN), "run speed");
        access(r == PMD_REQ_RUN, "run access");
    endtask
    task automatic wait_trip(input pmd_runreq_e r, input logic [1:0] k);
        logic vlp;
        pmd_mode_e wm;
        vlp = (r == PMD_REQ_LP_RUN);
        wm = vlp ? PMD_LP_WAIT : PMD_WAIT;
        run_cfg(r);
        deepSleepSel <= 1'b0;
        pulse(1'b1, k);
        chk(mode === wm, "wait entry");
        chk(ctrl.coreClkEn === 1'b0 && ctrl.periphClkEn === 1'b1,
            "wait en");
        chk(ctrl.lowVoltDetEn === ~vlp && ctrl.lowSpeedEn === vlp,
            "wait detector");
        access(~vlp, "wait access");
        pulse(1'b0, 2'h2);
        tick(12);
        chk(mode === wm, "async wake taken in wait");
        pulse(1'b0, 2'h1);
        chk(mode === runMode(r), "wait return");
    endtask
    task automatic stop_trip(input pmd_runreq_e r);
        int n;
        logic vlp;
        pmd_mode_e sm;
        vlp = (r == PMD_REQ_LP_RUN);
        sm = vlp ? PMD_LP_STOP : PMD_STOP;
        run_cfg(r);
        deepSleepSel <= 1'b1;
        pulse(1'b1, 2'h2);
        chk(mode === sm, "stop entry");
        chk(ctrl.coreClkEn === 1'b0 && ctrl.nestedIntEn === 1'b0
            && ctrl.asyncWakeEn === 1'b1, "stop core");
        if (vlp) begin
            chk(ctrl.sramRetain === 1'b1 && ctrl.serialDmaEn === 1'b1
                && ctrl.lowVoltDetEn === 1'b0 && ctrl.periphClkEn === 1'b0,
                "slow stop keep");
        end else begin
            chk(ctrl.periphClkEn === 1'b0 && ctrl.analogEn === 1'b1,
                "stop clocks");
            chk(ctrl.regRetain === 1'b1 && ctrl.sramRetain === 1'b1
                && ctrl.lowVoltDetEn === 1'b1, "stop keep");
        end
        access(~vlp, "stop access");
        pulse(1'b0, 2'h1);
        tick(2);
        chk(mode === sm, "nested wake taken in stop");
        pulse(1'b0, 2'h2);
        n = 0;
        while (ctrl.clkRestartReq === 1'b1 && n < 20) begin
            chk(mode === sm, "left stop before clocks");
            n++;
            tick(1);
        end
        chk(n == PMD_CLK_RESTART_CYC, "restart length");
        chk(mode === runMode(r), "stop return");
    endtask
    initial begin
        pmd_runreq_e cfgs[3];
        cfgs = '{PMD_REQ_RUN, PMD_REQ_HS_RUN, PMD_REQ_LP_RUN};
        repeat (6) @(posedge clk);
        @(negedge clk);
        chk(mode === PMD_RUN && ctrl === PMD_CTRL_RST, "reset state");
        rst_n <= 1'b1;
        tick(1);
        for (int i = 0; i < 3; i++) begin
            wait_trip(cfgs[i], 2'h1);
            wait_trip(cfgs[i], 2'h2);
            stop_trip(cfgs[i]);
        end
        // Slow run to fast run must step through normal run
        run_cfg(PMD_REQ_HS_RUN);
        tally_and_finish();
    end
    initial begin
        #20000;
        n_fail++;
        $display("unexpected at %0t: watchdog expired", $time);
        tally_and_finish();
    end
endmodule
